// ===== hdl/pfrs_pkg.sv
package pfrs_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 5;
    localparam int XTAL_WARMUP_NS = 20000;
    localparam int XTAL_WARMUP_CYC = (XTAL_WARMUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WARN_PERSIST_NS = 1000;
    localparam int WARN_PERSIST_CYC = (WARN_PERSIST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Dips shorter than this do not count as a power failure, except a low supply seen when ST_WAKE ends
    localparam int DIP_QUAL_NS = 100;
    localparam int DIP_QUAL_CYC = (DIP_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Lets a freshly enabled monitor pass through the synchronisers
    localparam int WAKE_SETTLE_CYC = 4;
    localparam int RING_FREQ_HZ = 8000;
    localparam int DETECT_RING_CYC = 2;
    localparam int CNT_W = 16;
    localparam int RING_W = 14;
    localparam logic [1:0] POLL_SEL_CONT = 2'h0;
    localparam int POLL_LOG2_BASE = 10;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] MASK_OFFSET = 8'h08;
    localparam logic [7:0] STATE_OFFSET = 8'h0c;
    localparam int CTRL_SMD_BIT = 0;
    localparam int CTRL_SEL_LSB = 1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0003;
    localparam int STAT_W = 3;
    localparam int STAT_WARN_BIT = 0;
    localparam int STAT_PFAIL_BIT = 1;
    localparam int STAT_RESTORE_BIT = 2;
    localparam logic [2:0] MASK_RESET = 3'h0;
    localparam int STATE_SUPPLY_LSB = 10;
    localparam int STATE_POWER_LSB = 13;
    localparam logic [15:0] PF_RESTART_ADDR = 16'h8000;
    localparam logic [15:0] POR_RESTART_ADDR = 16'h0000;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [8:0] {
        ST_OFF        = 9'h001,
        ST_WARMUP     = 9'h002,
        ST_RUN        = 9'h004,
        ST_EXTRST     = 9'h008,
        ST_STOP       = 9'h010,
        ST_WAKE       = 9'h020,
        ST_PF_SLEEP   = 9'h040,
        ST_PF_DETECT  = 9'h080,
        ST_PF_CONFIRM = 9'h100
    } pfrs_state_e;

    typedef struct packed {
        logic por_ok;
        logic rst_ok;
        logic warn_ok;
    } pfrs_supply_s;

    typedef struct packed {
        logic cpu_reset;
        logic regulator_on;
        logic crystal_on;
        logic monitor_on;
        logic sram_retain;
    } pfrs_power_s;

    localparam pfrs_power_s POWER_RESET = 5'h10;

endpackage

// ===== hdl/pfrs_sync.sv
`timescale 1ns/10ps
module pfrs_sync #(
    parameter int W = 1
) (
    input logic hclk,
    input logic hresetn,
    input logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_ff;

    // ****************************************
    // Two-stage synchroniser
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_ff <= '0;
            q <= '0;
        end else begin
            meta_ff <= d;
            q <= meta_ff;
        end
    end

endmodule

// ===== hdl/pfrs_sequencer.sv
`timescale 1ns/10ps
module pfrs_sequencer (
    input logic hclk,
    input logic hresetn,
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [2:0] hsize,
    input logic [31:0] hwdata,
    input logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input pfrs_pkg::pfrs_supply_s supply_in,
    input logic ring_osc_clk,
    input logic ext_reset_req,
    input logic stop_mode,
    input logic stop_wake,
    output pfrs_pkg::pfrs_power_s power_out,
    output logic [15:0] restart_addr,
    output logic irq
);

    // ****************************************
    // Synchronisers
    // ****************************************
    pfrs_pkg::pfrs_supply_s sup;
    logic [2:0] ctl_sync;
    logic ring_s;
    logic ext_rst_s;
    logic wake_s;
    logic ring_d_ff;
    logic ring_edge;

    pfrs_sync #(.W(3)) u_sync_supply (
        .hclk(hclk),
        .hresetn(hresetn),
        .d(supply_in),
        .q(sup)
    );

    pfrs_sync #(.W(3)) u_sync_ctl (
        .hclk(hclk),
        .hresetn(hresetn),
        .d({ring_osc_clk, ext_reset_req, stop_wake}),
        .q(ctl_sync)
    );

    assign ring_s = ctl_sync[2];
    assign ext_rst_s = ctl_sync[1];
    assign wake_s = ctl_sync[0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ring_d_ff <= 1'b0;
        end else begin
            ring_d_ff <= ring_s;
        end
    end

    // Rising edge of the slow ring oscillator paces polling, except with POLL_SEL_CONT where ST_PF_SLEEP leaves as soon as supply is good
    assign ring_edge = ring_s & ~ring_d_ff;

    // ****************************************
    // Registers
    // ****************************************
    logic smd_ff;
    logic [1:0] poll_sel_ff;
    logic [pfrs_pkg::STAT_W-1:0] status_ff;
    logic [pfrs_pkg::STAT_W-1:0] mask_ff;
    logic [pfrs_pkg::STAT_W-1:0] evt;
    logic [pfrs_pkg::STAT_W-1:0] nxt_status;
    logic wr_pend_ff;
    logic [7:0] waddr_ff;
    logic addr_ok;
    logic [31:0] rd_mux;

    pfrs_pkg::pfrs_state_e state_ff;
    pfrs_pkg::pfrs_state_e nxt_state;

    assign addr_ok = hsel & hready & (htrans == pfrs_pkg::HTRANS_NONSEQ);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            waddr_ff <= 8'h00;
        end else begin
            wr_pend_ff <= addr_ok & hwrite;
            if (addr_ok) begin
                waddr_ff <= haddr[7:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            smd_ff <= pfrs_pkg::CTRL_RESET[pfrs_pkg::CTRL_SMD_BIT];
            poll_sel_ff <= pfrs_pkg::CTRL_RESET[pfrs_pkg::CTRL_SEL_LSB +: 2];
            mask_ff <= pfrs_pkg::MASK_RESET;
        end else if (wr_pend_ff) begin
            if (waddr_ff == pfrs_pkg::CTRL_OFFSET) begin
                smd_ff <= hwdata[pfrs_pkg::CTRL_SMD_BIT];
                poll_sel_ff <= hwdata[pfrs_pkg::CTRL_SEL_LSB +: 2];
            end
            if (waddr_ff == pfrs_pkg::MASK_OFFSET) begin
                mask_ff <= hwdata[pfrs_pkg::STAT_W-1:0];
            end
        end
    end

    // A new event wins over a write-one-to-clear in the same cycle
    always_comb begin
        nxt_status = status_ff;
        if (wr_pend_ff && waddr_ff == pfrs_pkg::STATUS_OFFSET) begin
            nxt_status = status_ff & ~hwdata[pfrs_pkg::STAT_W-1:0];
        end
        nxt_status = nxt_status | evt;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_ff <= '0;
            irq <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            irq <= |(nxt_status & mask_ff);
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (haddr[7:0])
            pfrs_pkg::CTRL_OFFSET: begin
                rd_mux[pfrs_pkg::CTRL_SMD_BIT] = smd_ff;
                rd_mux[pfrs_pkg::CTRL_SEL_LSB +: 2] = poll_sel_ff;
            end
            pfrs_pkg::STATUS_OFFSET: rd_mux[pfrs_pkg::STAT_W-1:0] = status_ff;
            pfrs_pkg::MASK_OFFSET: rd_mux[pfrs_pkg::STAT_W-1:0] = mask_ff;
            pfrs_pkg::STATE_OFFSET: begin
                rd_mux[8:0] = state_ff;
                rd_mux[pfrs_pkg::STATE_SUPPLY_LSB +: 3] = sup;
                rd_mux[pfrs_pkg::STATE_POWER_LSB +: 5] = power_out;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Zero wait states; read data is taken in the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (addr_ok && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    // ****************************************
    // Supply qualification
    // ****************************************
    logic [pfrs_pkg::CNT_W-1:0] dip_cnt_ff;
    logic [pfrs_pkg::CNT_W-1:0] warn_cnt_ff;
    logic dip_qual;
    logic warn_hit;
    logic in_warn_band;

    assign in_warn_band = sup.rst_ok & ~sup.warn_ok;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dip_cnt_ff <= '0;
        end else if (sup.rst_ok) begin
            dip_cnt_ff <= '0;
        end else if (!dip_qual) begin
            dip_cnt_ff <= dip_cnt_ff + 1'b1;
        end
    end

    // Only a dip that outlasts the qualification window counts
    assign dip_qual = (dip_cnt_ff == pfrs_pkg::CNT_W'(pfrs_pkg::DIP_QUAL_CYC));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            warn_cnt_ff <= '0;
        end else if (!in_warn_band || !(state_ff inside {pfrs_pkg::ST_RUN, pfrs_pkg::ST_EXTRST})) begin
            warn_cnt_ff <= '0;
        end else if (warn_cnt_ff != pfrs_pkg::CNT_W'(pfrs_pkg::WARN_PERSIST_CYC)) begin
            warn_cnt_ff <= warn_cnt_ff + 1'b1;
        end
    end

    // One pulse per stay in the warning band lasting WARN_PERSIST_CYC cycles in ST_RUN or ST_EXTRST
    assign warn_hit = (warn_cnt_ff == pfrs_pkg::CNT_W'(pfrs_pkg::WARN_PERSIST_CYC - 1));

    // ****************************************
    // Sequencer
    // ****************************************
    logic [pfrs_pkg::CNT_W-1:0] cyc_cnt_ff;
    logic [pfrs_pkg::RING_W-1:0] ring_cnt_ff;
    logic [pfrs_pkg::RING_W-1:0] poll_last;
    logic warm_done;
    logic wake_done;

    // Poll period is 2^(10+sel) ring clocks
    assign poll_last = pfrs_pkg::RING_W'((1 << (pfrs_pkg::POLL_LOG2_BASE + poll_sel_ff)) - 1);
    assign warm_done = (cyc_cnt_ff == pfrs_pkg::CNT_W'(pfrs_pkg::XTAL_WARMUP_CYC - 1));
    assign wake_done = (cyc_cnt_ff == pfrs_pkg::CNT_W'(pfrs_pkg::WAKE_SETTLE_CYC - 1));

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            pfrs_pkg::ST_OFF: begin
                if (sup.por_ok) nxt_state = pfrs_pkg::ST_WARMUP;
            end
            pfrs_pkg::ST_WARMUP: begin
                // CPU stays in reset until the crystal is ready and supply is good
                if (warm_done && sup.rst_ok) begin
                    nxt_state = ext_rst_s ? pfrs_pkg::ST_EXTRST : pfrs_pkg::ST_RUN;
                end
            end
            pfrs_pkg::ST_RUN: begin
                if (dip_qual) nxt_state = pfrs_pkg::ST_PF_SLEEP;
                else if (ext_rst_s) nxt_state = pfrs_pkg::ST_EXTRST;
                else if (stop_mode) nxt_state = pfrs_pkg::ST_STOP;
            end
            pfrs_pkg::ST_EXTRST: begin
                if (dip_qual) nxt_state = pfrs_pkg::ST_PF_SLEEP;
                else if (!ext_rst_s) nxt_state = pfrs_pkg::ST_RUN;
            end
            pfrs_pkg::ST_STOP: begin
                if (!smd_ff && dip_qual) nxt_state = pfrs_pkg::ST_PF_SLEEP;
                else if (wake_s || !stop_mode) begin
                    nxt_state = smd_ff ? pfrs_pkg::ST_WAKE : pfrs_pkg::ST_RUN;
                end
            end
            pfrs_pkg::ST_WAKE: begin
                // Monitor was just switched on; judge once it has settled
                if (wake_done) begin
                    nxt_state = sup.rst_ok ? pfrs_pkg::ST_RUN : pfrs_pkg::ST_PF_SLEEP;
                end
            end
            pfrs_pkg::ST_PF_SLEEP: begin
                if (poll_sel_ff == pfrs_pkg::POLL_SEL_CONT) begin
                    if (sup.rst_ok) nxt_state = pfrs_pkg::ST_PF_DETECT;
                end else if (ring_edge && ring_cnt_ff == poll_last) begin
                    nxt_state = pfrs_pkg::ST_PF_DETECT;
                end
            end
            pfrs_pkg::ST_PF_DETECT: begin
                if (!sup.rst_ok) nxt_state = pfrs_pkg::ST_PF_SLEEP;
                else if (ring_edge &&
                         ring_cnt_ff == pfrs_pkg::RING_W'(pfrs_pkg::DETECT_RING_CYC - 1)) begin
                    nxt_state = pfrs_pkg::ST_PF_CONFIRM;
                end
            end
            pfrs_pkg::ST_PF_CONFIRM: begin
                if (!sup.rst_ok) nxt_state = pfrs_pkg::ST_PF_SLEEP;
                else if (ring_edge) nxt_state = pfrs_pkg::ST_WARMUP;
            end
            default: nxt_state = pfrs_pkg::ST_OFF;
        endcase
        if (!sup.por_ok) begin
            nxt_state = pfrs_pkg::ST_OFF;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= pfrs_pkg::ST_OFF;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Counters restart on every state change
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cyc_cnt_ff <= '0;
        end else if (nxt_state != state_ff) begin
            cyc_cnt_ff <= '0;
        end else if (!warm_done) begin
            cyc_cnt_ff <= cyc_cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ring_cnt_ff <= '0;
        end else if (nxt_state != state_ff) begin
            ring_cnt_ff <= '0;
        end else if (ring_edge) begin
            ring_cnt_ff <= ring_cnt_ff + 1'b1;
        end
    end

    // ****************************************
    // Events
    // ****************************************
    always_comb begin
        evt = '0;
        evt[pfrs_pkg::STAT_WARN_BIT] = warn_hit |
            (state_ff == pfrs_pkg::ST_WAKE && wake_done && in_warn_band);
        evt[pfrs_pkg::STAT_PFAIL_BIT] = (nxt_state == pfrs_pkg::ST_PF_SLEEP) &&
            !(state_ff inside {pfrs_pkg::ST_PF_SLEEP, pfrs_pkg::ST_PF_DETECT,
                               pfrs_pkg::ST_PF_CONFIRM});
        evt[pfrs_pkg::STAT_RESTORE_BIT] = (state_ff == pfrs_pkg::ST_PF_CONFIRM) &&
            (nxt_state == pfrs_pkg::ST_WARMUP);
    end

    // ****************************************
    // Power controls
    // ****************************************
    pfrs_pkg::pfrs_power_s nxt_power;

    always_comb begin
        nxt_power = pfrs_pkg::POWER_RESET;
        unique case (nxt_state)
            pfrs_pkg::ST_OFF: nxt_power = pfrs_pkg::POWER_RESET;
            pfrs_pkg::ST_WARMUP: begin
                nxt_power = '{cpu_reset: 1'b1, regulator_on: 1'b1, crystal_on: 1'b1,
                              monitor_on: 1'b1, sram_retain: 1'b0};
            end
            pfrs_pkg::ST_RUN: begin
                nxt_power = '{cpu_reset: 1'b0, regulator_on: 1'b1, crystal_on: 1'b1,
                              monitor_on: 1'b1, sram_retain: 1'b0};
            end
            pfrs_pkg::ST_EXTRST: begin
                nxt_power = '{cpu_reset: 1'b1, regulator_on: 1'b1, crystal_on: 1'b1,
                              monitor_on: 1'b1, sram_retain: 1'b0};
            end
            pfrs_pkg::ST_STOP: begin
                nxt_power = '{cpu_reset: 1'b0, regulator_on: 1'b0, crystal_on: 1'b0,
                              monitor_on: !smd_ff, sram_retain: 1'b1};
            end
            pfrs_pkg::ST_WAKE: begin
                nxt_power = '{cpu_reset: 1'b0, regulator_on: 1'b0, crystal_on: 1'b0,
                              monitor_on: 1'b1, sram_retain: 1'b1};
            end
            pfrs_pkg::ST_PF_SLEEP: begin
                nxt_power = '{cpu_reset: 1'b1, regulator_on: 1'b0, crystal_on: 1'b0,
                              monitor_on: (poll_sel_ff == pfrs_pkg::POLL_SEL_CONT),
                              sram_retain: 1'b1};
            end
            pfrs_pkg::ST_PF_DETECT, pfrs_pkg::ST_PF_CONFIRM: begin
                nxt_power = '{cpu_reset: 1'b1, regulator_on: 1'b0, crystal_on: 1'b0,
                              monitor_on: 1'b1, sram_retain: 1'b1};
            end
            default: nxt_power = pfrs_pkg::POWER_RESET;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            power_out <= pfrs_pkg::POWER_RESET;
        end else begin
            power_out <= nxt_power;
        end
    end

    // Restart vector is latched when warm-up begins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            restart_addr <= pfrs_pkg::POR_RESTART_ADDR;
        end else if (state_ff == pfrs_pkg::ST_PF_CONFIRM && nxt_state == pfrs_pkg::ST_WARMUP) begin
            restart_addr <= pfrs_pkg::PF_RESTART_ADDR;
        end else if (state_ff == pfrs_pkg::ST_OFF && nxt_state == pfrs_pkg::ST_WARMUP) begin
            restart_addr <= pfrs_pkg::POR_RESTART_ADDR;
        end
    end

endmodule

// ===== testbench/pfrs_checker.sv
`timescale 1ns/10ps
module pfrs_checker (
    input logic hclk,
    input logic hresetn,
    input logic hreadyout,
    input logic hresp,
    input pfrs_pkg::pfrs_supply_s supply_in,
    input logic ext_reset_req,
    input logic stop_mode,
    input pfrs_pkg::pfrs_power_s power_out
);
    // ****************************************
    // Helper counters
    // ****************************************
    // Slack of two cycles covers where the state register samples crystal_on
    localparam int WARM_MIN = pfrs_pkg::XTAL_WARMUP_CYC - 2;
    logic [7:0] low_cnt_ff;
    logic [15:0] warm_cnt_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_cnt_ff <= 8'h00;
        end else if (!supply_in.por_ok || supply_in.rst_ok || stop_mode) begin
            low_cnt_ff <= 8'h00;
        end else if (low_cnt_ff != 8'hff) begin
            low_cnt_ff <= low_cnt_ff + 8'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            warm_cnt_ff <= 16'h0000;
        end else if (!power_out.crystal_on) begin
            warm_cnt_ff <= 16'h0000;
        end else if (warm_cnt_ff != 16'hffff) begin
            warm_cnt_ff <= warm_cnt_ff + 16'h0001;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_long_fail;
        low_cnt_ff == 8'd30 && !$past(power_out.cpu_reset, 30);
    endsequence
    sequence s_short_dip;
        $past(low_cnt_ff) inside {[8'd1:8'd10]} && low_cnt_ff == 8'd0 && supply_in.rst_ok
            && !power_out.cpu_reset && !ext_reset_req;
    endsequence
    sequence s_ext_end;
        $fell(ext_reset_req) && supply_in == 3'h7 && !stop_mode && power_out.crystal_on;
    endsequence

    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_off_below_por: assert property ((!supply_in.por_ok)[*5] |->
        power_out == pfrs_pkg::POWER_RESET)
        else $error("power not off below power-on level");
    a_run_powered: assert property (!power_out.cpu_reset && !power_out.sram_retain |->
        power_out.regulator_on && power_out.crystal_on)
        else $error("cpu running without regulator or crystal");
    a_ext_keep_on: assert property ((ext_reset_req && supply_in == 3'h7)[*6] |->
        power_out.cpu_reset && power_out.regulator_on && power_out.crystal_on
        && power_out.monitor_on)
        else $error("external reset did not keep supplies on");
    a_ext_release: assert property (s_ext_end |-> ##[1:19] !power_out.cpu_reset)
        else $error("external reset released too late");
    a_pf_sleep: assert property (s_long_fail |-> power_out.cpu_reset
        && !power_out.regulator_on && !power_out.crystal_on && power_out.sram_retain)
        else $error("power fail did not enter retained reset");
    a_dip_ignored: assert property (s_short_dip |-> (!power_out.cpu_reset)[*8])
        else $error("short dip caused a reset");
    a_warm_release: assert property ($fell(power_out.cpu_reset) |->
        warm_cnt_ff >= WARM_MIN)
        else $error("cpu released before crystal warm-up");
endmodule

bind pfrs_sequencer pfrs_checker u_checker (.hclk(hclk), .hresetn(hresetn),
    .hreadyout(hreadyout), .hresp(hresp), .supply_in(supply_in),
    .ext_reset_req(ext_reset_req), .stop_mode(stop_mode), .power_out(power_out));

// ===== testbench/pfrs_supply_model.sv
`timescale 1ns/10ps
module pfrs_supply_model (
    input logic hclk,
    input logic hresetn,
    input logic [1:0] band,
    output pfrs_pkg::pfrs_supply_s supply_in,
    output logic ring_osc_clk
);
    // ****************************************
    // Comparators and ring oscillator
    // ****************************************
    logic [1:0] div_ff;

    // Band 0 below power-on, 1 below reset, 2 below warning, 3 above all
    assign supply_in.por_ok = (band >= 2'h1);
    assign supply_in.rst_ok = (band >= 2'h2);
    assign supply_in.warn_ok = (band == 2'h3);

    // Sped up ring: three crystal cycles per level keeps polls short
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_ff <= 2'h0;
            ring_osc_clk <= 1'b0;
        end else if (div_ff == 2'h2) begin
            div_ff <= 2'h0;
            ring_osc_clk <= ~ring_osc_clk;
        end else begin
            div_ff <= div_ff + 2'h1;
        end
    end
endmodule

// ===== testbench/tb.sv
`timescale 1ns/10ps
module tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic ext_reset_req = 1'b0;
    logic stop_mode = 1'b0;
    logic stop_wake = 1'b0;
    logic [1:0] band = 2'h0;
    logic hready;
    logic [31:0] hrdata;
    logic hresp;
    logic ring_osc_clk;
    logic irq;
    logic [15:0] restart_addr;
    pfrs_pkg::pfrs_supply_s supply_in;
    pfrs_pkg::pfrs_power_s power_out;
    int error_cnt = 0;
    int checks = 0;
    int k;
    logic [31:0] v;

    always #2.5 hclk = ~hclk;

    pfrs_sequencer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .supply_in(supply_in),
        .ring_osc_clk(ring_osc_clk), .ext_reset_req(ext_reset_req), .stop_mode(stop_mode),
        .stop_wake(stop_wake), .power_out(power_out), .restart_addr(restart_addr), .irq(irq));

    pfrs_supply_model u_supply (.hclk(hclk), .hresetn(hresetn), .band(band),
        .supply_in(supply_in), .ring_osc_clk(ring_osc_clk));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Entered just after a rising edge; returns at the edge that takes read data
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= pfrs_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        v = hrdata;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        chk(v, exp);
    endtask

    task automatic give_verdict;
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        #400000;
        error_cnt++;
        give_verdict();
    end

    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk(32'(power_out), 32'(pfrs_pkg::POWER_RESET));
        rdc(pfrs_pkg::CTRL_OFFSET, pfrs_pkg::CTRL_RESET);
        rdc(pfrs_pkg::MASK_OFFSET, 32'h0);
        rdc(8'h40, 32'h0);
        band <= 2'h3;
        repeat (8) @(posedge hclk);
        chk(32'(power_out[4:2]), 32'h7);
        for (k = 0; k < 6000 && power_out.cpu_reset !== 1'b0; k++) @(posedge hclk);
        chk(32'(k > pfrs_pkg::XTAL_WARMUP_CYC - 12), 32'h1);
        chk(32'(restart_addr), 32'(pfrs_pkg::POR_RESTART_ADDR));
        band <= 2'h1;
        repeat (10) @(posedge hclk);
        band <= 2'h3;
        repeat (40) @(posedge hclk);
        chk(32'(power_out.cpu_reset), 32'h0);
        rdc(pfrs_pkg::STATUS_OFFSET, 32'h0);
        band <= 2'h2;
        repeat (250) @(posedge hclk);
        band <= 2'h3;
        rdc(pfrs_pkg::STATUS_OFFSET, 32'h1);
        chk(32'(irq), 32'h0);
        chk(32'(power_out.cpu_reset), 32'h0);
        ahb(1'b1, pfrs_pkg::MASK_OFFSET, 32'h1);
        // Mask lands at the data-phase edge; irq follows one edge later
        repeat (2) @(posedge hclk);
        chk(32'(irq), 32'h1);
        ahb(1'b1, pfrs_pkg::STATUS_OFFSET, 32'h1);
        @(posedge hclk);
        chk(32'(irq), 32'h0);
        ext_reset_req <= 1'b1;
        repeat (10) @(posedge hclk);
        chk(32'(power_out[4:1]), 32'hf);
        ext_reset_req <= 1'b0;
        for (k = 0; k < 40 && power_out.cpu_reset !== 1'b0; k++) @(posedge hclk);
        chk(32'(k < 20), 32'h1);
        band <= 2'h1;
        for (k = 0; k < 100 && power_out.crystal_on !== 1'b0; k++) @(posedge hclk);
        chk(32'(power_out), 32'h11);
        band <= 2'h3;
        for (k = 0; k < 14000 && power_out.monitor_on !== 1'b1; k++) @(posedge hclk);
        chk(32'(k >= 12200 && k <= 12400), 32'h1);
        for (k = 0; k < 100 && power_out.crystal_on !== 1'b1; k++) @(posedge hclk);
        chk(32'(k >= 10 && k <= 30), 32'h1);
        for (k = 0; k < 6000 && power_out.cpu_reset !== 1'b0; k++) @(posedge hclk);
        chk(32'(restart_addr), 32'(pfrs_pkg::PF_RESTART_ADDR));
        rdc(pfrs_pkg::STATUS_OFFSET, 32'h6);
        ahb(1'b1, pfrs_pkg::STATUS_OFFSET, 32'h7);
        ahb(1'b1, pfrs_pkg::CTRL_OFFSET, 32'h1);
        stop_mode <= 1'b1;
        repeat (10) @(posedge hclk);
        chk(32'(power_out), 32'h01);
        band <= 2'h1;
        repeat (40) @(posedge hclk);
        chk(32'(power_out), 32'h01);
        stop_wake <= 1'b1;
        repeat (4) @(posedge hclk);
        stop_wake <= 1'b0;
        for (k = 0; k < 40 && power_out.cpu_reset !== 1'b1; k++) @(posedge hclk);
        chk(32'(power_out[4:1]), 32'h9);
        stop_mode <= 1'b0;
        band <= 2'h3;
        for (k = 0; k < 6000 && power_out.cpu_reset !== 1'b0; k++) @(posedge hclk);
        chk(32'(restart_addr), 32'(pfrs_pkg::PF_RESTART_ADDR));
        band <= 2'h0;
        repeat (8) @(posedge hclk);
        chk(32'(power_out), 32'(pfrs_pkg::POWER_RESET));
        give_verdict();
    end
endmodule
